//--- hdl/dac_word_pkg.sv
// Constants and carrier types for the two-byte converter word slave.
// Assumes one 20 MHz system clock and a synchronous active-low reset.
// Overview of operation
// - Bytes arrive high byte first, MSB first, into a 16-bit input word.
// - A completed two-byte word is copied into the converter register.
// - A set top word bit puts the converter into soft power-down.
// - The 10-bit converter code is word bits 13 down to 4, bit 13 as MSB.
// - Word bit 14 and bits 3 down to 0 are ignored.
// - Reads return the word in the write order and field layout.
// - The slave answers address 0001100 with its two low bits ignored.
// - Every input word bit is cleared after each read completes.
// - Each transaction carries two data bytes; written bytes are acknowledged, the last read byte is not.
`default_nettype none
package dac_word_pkg;
  localparam logic [4:0]  DEV_ADDR_TOP   = 5'h03;
  localparam int          PD_BIT_POS     = 15;
  localparam int          CODE_MSB_POS   = 13;
  localparam int          CODE_LSB_POS   = 4;
  localparam logic [15:0] WORD_RESET     = 16'h0000;
  localparam logic [9:0]  CODE_RESET     = 10'h000;
  localparam logic [3:0]  BIT_CNT_RESET  = 4'h0;
  localparam logic [3:0]  ACK_SLOT       = 4'h8;

  typedef struct packed {
    logic       soft_powerdown_bit;
    logic [9:0] code;
  } conv_s;
endpackage
`default_nettype wire

//--- hdl/pin_sync.sv
// Two-flop synchroniser for the serial bus pins.
// Assumes asynchronous level inputs and the system clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      stage1 <= '1;
      sync_o <= '1;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end
endmodule
`default_nettype wire

//--- hdl/dac_input_word_format.sv
// Serial bus slave that loads a 16-bit input word into a 10-bit converter.
// Assumes pull-ups on both bus lines and a bus clock far below clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module dac_input_word_format (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [9:0]      code_o,
  output logic            soft_powerdown_bit_o
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WR   = 5'b00100,
    ST_RD   = 5'b01000,
    ST_SKIP = 5'b10000
  } state_e;

  state_e               state;
  logic [1:0]           pins;
  logic                 scl;
  logic                 sda;
  logic                 scl_q;
  logic                 sda_q;
  logic                 scl_rise;
  logic                 scl_fall;
  logic                 start_c;
  logic                 stop_c;
  logic [3:0]           bit_cnt;
  logic                 byte_idx;
  logic [7:0]           shift;
  logic [15:0]          serial_input_word;
  logic                 read_done;
  logic                 addr_acked;
  dac_word_pkg::conv_s  conv;

  pin_sync #(.WIDTH(2)) pin_sync_inst (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .async_i   ({scl_i, sda_i}),
    .sync_o    (pins)
  );
  assign scl = pins[1];
  assign sda = pins[0];

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end
  assign scl_rise = scl & ~scl_q;
  assign scl_fall = ~scl & scl_q;
  assign start_c  = scl & scl_q & sda_q & ~sda;
  assign stop_c   = scl & scl_q & ~sda_q & sda;

  // Bit counter: 0..7 data bits, 8 is the acknowledge slot.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      state    <= ST_IDLE;
      bit_cnt  <= dac_word_pkg::BIT_CNT_RESET;
      byte_idx <= 1'b0;
      shift    <= 8'h00;
      sda_o    <= 1'b0;
      sda_oe_o <= 1'b0;
      read_done <= 1'b0;
      addr_acked <= 1'b0;
    end else begin
      read_done <= 1'b0;
      if (start_c) begin
        state    <= ST_ADDR;
        addr_acked <= 1'b0;
        bit_cnt  <= dac_word_pkg::BIT_CNT_RESET;
        byte_idx <= 1'b0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else if (scl_rise && state != ST_IDLE && state != ST_SKIP) begin
        if (bit_cnt != dac_word_pkg::ACK_SLOT) begin
          shift   <= {shift[6:0], sda};
          bit_cnt <= bit_cnt + 4'h1;
        end else begin
          bit_cnt <= dac_word_pkg::BIT_CNT_RESET;
          if (addr_acked) begin
            // The address acknowledge slot carries no data byte.
            addr_acked <= 1'b0;
          end else if (state == ST_RD) begin
            // Master NACK or second byte ends the read.
            if (sda || byte_idx) begin
              read_done <= 1'b1;
              state     <= ST_SKIP;
            end
            byte_idx <= 1'b1;
          end else if (state == ST_WR) begin
            byte_idx <= ~byte_idx;
          end
        end
      end else if (scl_fall && state != ST_IDLE && state != ST_SKIP) begin
        if (bit_cnt == dac_word_pkg::ACK_SLOT) begin
          if (state == ST_ADDR) begin
            if (shift[7:3] == dac_word_pkg::DEV_ADDR_TOP) begin
              sda_o    <= 1'b0;
              sda_oe_o <= 1'b1;
              state    <= shift[0] ? ST_RD : ST_WR;
              addr_acked <= 1'b1;
            end else begin
              state    <= ST_SKIP;
              sda_oe_o <= 1'b0;
            end
          end else if (state == ST_WR) begin
            sda_o    <= 1'b0;
            sda_oe_o <= 1'b1;
          end else begin
            sda_oe_o <= 1'b0;
          end
        end else if (state == ST_RD) begin
          sda_o <= byte_idx ? serial_input_word[4'h7 - bit_cnt[2:0]]
                            : serial_input_word[4'hf - {1'b0, bit_cnt[2:0]}];
          sda_oe_o <= 1'b1;
          if (bit_cnt == dac_word_pkg::BIT_CNT_RESET && state == ST_RD &&
              byte_idx == 1'b0 && shift[0]) begin
            sda_oe_o <= 1'b1;
          end
        end else begin
          sda_oe_o <= 1'b0;
        end
      end
    end
  end

  logic wr_byte_done;
  assign wr_byte_done = scl_rise && state == ST_WR && !addr_acked &&
                        bit_cnt == dac_word_pkg::ACK_SLOT;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      serial_input_word <= dac_word_pkg::WORD_RESET;
    end else if (read_done) begin
      serial_input_word <= dac_word_pkg::WORD_RESET;
    end else if (wr_byte_done && !byte_idx) begin
      serial_input_word[15:8] <= shift;
    end else if (wr_byte_done && byte_idx) begin
      serial_input_word[7:0] <= shift;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      conv <= '{soft_powerdown_bit: 1'b0, code: dac_word_pkg::CODE_RESET};
    end else if (wr_byte_done && byte_idx) begin
      conv.soft_powerdown_bit <=
        serial_input_word[dac_word_pkg::PD_BIT_POS];
      conv.code <= {serial_input_word[13:8], shift[7:4]};
    end
  end
  assign code_o               = conv.code;
  assign soft_powerdown_bit_o = conv.soft_powerdown_bit;

  // The code must equal the word field once the full word has landed.
  word_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (wr_byte_done && byte_idx) |=> code_o ==
    serial_input_word[dac_word_pkg::CODE_MSB_POS:dac_word_pkg::CODE_LSB_POS])
    else $error("Code not loaded from word.");

  hold_code_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !(wr_byte_done && byte_idx) |=> $stable(code_o))
    else $error("Code changed without full word.");

  hold_pd_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    !(wr_byte_done && byte_idx) |=> $stable(soft_powerdown_bit_o))
    else $error("Power-down changed without full word.");

  pd_load_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (wr_byte_done && byte_idx) |=> soft_powerdown_bit_o ==
    serial_input_word[dac_word_pkg::PD_BIT_POS])
    else $error("Power-down not loaded.");

  read_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    read_done |=> serial_input_word == dac_word_pkg::WORD_RESET)
    else $error("Word not cleared after read.");

  addr_skip_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (state == ST_SKIP) |-> !sda_oe_o || $past(state) != ST_SKIP)
    else $error("Drive while not addressed.");

  addr_ack_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (scl_fall && state == ST_ADDR && bit_cnt == dac_word_pkg::ACK_SLOT &&
    shift[7:3] == dac_word_pkg::DEV_ADDR_TOP) |=> sda_oe_o && !sda_o)
    else $error("Own address not acknowledged.");

  wr_ack_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (scl_fall && state == ST_WR && bit_cnt == dac_word_pkg::ACK_SLOT)
    |=> sda_oe_o && !sda_o)
    else $error("Written byte not acknowledged.");

  ack_low_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (sda_oe_o && state == ST_WR) |-> !sda_o)
    else $error("Write phase drives a high level.");

  rd_first_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (scl_fall && state == ST_RD && !byte_idx &&
    bit_cnt == dac_word_pkg::BIT_CNT_RESET) |=> sda_oe_o &&
    sda_o == serial_input_word[dac_word_pkg::PD_BIT_POS])
    else $error("Read does not open with the top word bit.");

  rd_release_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (scl_fall && state == ST_RD && bit_cnt == dac_word_pkg::ACK_SLOT)
    |=> !sda_oe_o)
    else $error("Data line held in master acknowledge slot.");

  start_clear_a: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    start_c |=> state == ST_ADDR && !sda_oe_o &&
    bit_cnt == dac_word_pkg::BIT_CNT_RESET)
    else $error("Start did not restart the frame.");
endmodule
`default_nettype wire

//--- bench/i2c_host_model.sv
// Bus master model that frames writes and reads for the converter slave.
// Assumes a pulled-up data line whose level the bench resolves.
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  localparam int HALF = 20;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
    #5;
  endtask
  task automatic bit_c(input logic b, output logic r);
    sda_o = b;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    r = sda_i;
    scl_o = 1'b0;
    wt(4);
  endtask
  // Sends start, address, nb data bytes and stop; ack slots return in ak.
  task automatic xact(input logic [7:0] ad, input logic [15:0] wd,
                      input int nb, output logic [15:0] rd,
                      output logic [2:0] ak);
    logic [23:0] tx;
    logic [23:0] rx;
    tx = {ad, wd};
    sda_o = 1'b1;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b0;
    wt(4);
    for (int k = 0; k <= nb; k++) begin
      for (int i = 0; i < 8; i++) begin
        bit_c(ad[0] && k > 0 ? 1'b1 : tx[23-8*k-i], rx[23-8*k-i]);
      end
      bit_c(ad[0] && k == 1 ? 1'b0 : 1'b1, ak[k]);
    end
    rd = rx[15:0];
    sda_o = 1'b0;
    wt(HALF);
    scl_o = 1'b1;
    wt(HALF);
    sda_o = 1'b1;
    wt(HALF);
  endtask
endmodule
`default_nettype wire

//--- bench/tb_dac_input_word_format.sv
// Self-checking bench for the converter word slave.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_dac_input_word_format;
  logic        clk_sys_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        scl;
  logic        m_sda;
  logic        sda;
  logic        sda_o;
  logic        sda_oe_o;
  logic        pd;
  logic [9:0]  code;
  logic [15:0] rd;
  logic [2:0]  ak;
  logic [15:0] words [4] = '{16'hc00f, 16'h2a5a, 16'h7ff0, 16'h8017};
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  assign sda = (sda_oe_o ? sda_o : 1'b1) & m_sda;
  dac_input_word_format dac_input_word_format_inst (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o), .code_o(code),
    .soft_powerdown_bit_o(pd));
  i2c_host_model i2c_host_model_inst (
    .clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .sda_o(m_sda));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic chk_out(input logic [15:0] w);
    check({pd, 5'h00, code}, {w[15], 5'h00, w[13:4]});
  endtask
  task automatic wrap_up();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_i);
    #5;
    resetn_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk_out(16'h0000);
    for (int j = 0; j < 4; j++) begin
      i2c_host_model_inst.xact(8'h18 + 8'(2*j), words[j], 2, rd, ak);
      check(16'(ak[0]), 16'h0000);
      check(16'(ak[2:1]), 16'h0000);
      chk_out(words[j]);
    end
    i2c_host_model_inst.xact(8'h19, 16'h0000, 2, rd, ak);
    check(16'(ak[0]), 16'h0000);
    check(rd, 16'h8017);
    i2c_host_model_inst.xact(8'h1f, 16'h0000, 2, rd, ak);
    check(rd, 16'h0000);
    chk_out(16'h8017);
    i2c_host_model_inst.xact(8'h30, 16'h3ff0, 2, rd, ak);
    check(16'(ak[0]), 16'h0001);
    chk_out(16'h8017);
    i2c_host_model_inst.xact(8'h18, 16'h5a00, 1, rd, ak);
    chk_out(16'h8017);
    i2c_host_model_inst.xact(8'h1e, 16'h3ff0, 2, rd, ak);
    chk_out(16'h3ff0);
    wrap_up();
  end
endmodule
`default_nettype wire
